/* File: ext_bus_ctrl.sv */
// External bus cycle control: ready wait states and hold arbitration, with an AXI4-Lite port.
// Assumes the internal bus controller holds cycle_req_i until cycle_done_o pulses.
// Contract
// - At the ready sample, ready high adds a wait state; low ends the cycle.
// - Async mode uses the synchroniser; sync mode samples ready on the bus clock edge.
// - Programmed memory wait states, possibly zero, come before the ready sample.
// - The command's leading edge follows the read/write delay option.
// - Multiplexed mode adds one wait after each cycle, plus an optional tristate wait.
// - Gap is two bus clocks for mux with tristate, zero for demux without.
// - Hold is sampled on bus clock edges; acknowledge and regain request driven there.
// - A running cycle finishes before hold acknowledge and bus release.
// - On release the chip selects are not driven; pull-ups hold them high.
// - Regain starts only when hold is removed, even after an early regain request.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
module ext_bus_ctrl
	import ext_bus_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	// AXI4-Lite
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Internal bus controller
	input  wire logic              cycle_req_i,
	input  wire logic              cycle_we_i,
	input  wire logic [CS_NUM-1:0] cycle_cs_i,
	output logic                   cycle_done_o,
	// Pins
	output logic                   bus_clock_output_o,
	input  wire logic              ready_n_i,
	input  wire logic              hold_n_i,
	output logic                   hold_acknowledge_n_o,
	output logic                   bus_regain_request_n_o,
	output logic [CS_NUM-1:0]      chip_select_outputs_n_o,
	output logic                   chip_select_outputs_oe_o,
	output logic                   rd_n_o,
	output logic                   wr_n_o,
	output logic                   bus_oe_o
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                  phase;
		bus_state_t            st;
		logic                  we;
		logic [CS_NUM-1:0]     cs_n;
		logic                  cs_oe;
		logic                  rd_n;
		logic                  wr_n;
		logic                  bus_oe;
		logic                  hold_acknowledge_n;
		logic                  bus_regain_request_n;
		logic                  done;
		logic [WAIT_CNT_W-1:0] waits;
		logic [WAIT_CNT_W-1:0] last_waits;
		logic [CTRL_W-1:0]     ctrl;
		logic                  aw_have;
		logic [ADDR_W-1:0]     aw_addr;
		logic                  w_have;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} regs_t;

	regs_t q, d;

	logic tick;
	logic rdy_direct_n, rdy_stable_n, rdy_n;
	logic hold_stable_n;
	logic mc_load, mc_dec, mc_last;
	logic [MEMORY_CYCLE_WAIT_STATES_W-1:0] memory_cycle_wait_states;

	// ----------------------------------------------------------------
	// Pin synchronisers and wait counter
	// ----------------------------------------------------------------
	pin_sync #(.RST_VAL(1'b1)) u_ready_sync (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.pin_i    (ready_n_i),
		.direct_o (rdy_direct_n),
		.stable_o (rdy_stable_n)
	);

	pin_sync #(.RST_VAL(1'b1)) u_hold_sync (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.pin_i    (hold_n_i),
		.direct_o (),
		.stable_o (hold_stable_n)
	);

	wait_counter u_memory_cycle_wait_states (
		.clk_i      (clk_i),
		.nrst_i     (nrst_i),
		.load_i     (mc_load),
		.load_val_i (memory_cycle_wait_states),
		.dec_i      (mc_dec),
		.last_o     (mc_last)
	);

	// Bus clock is half the core clock; every bus move happens as it falls
	assign tick = q.phase;
	assign memory_cycle_wait_states = q.ctrl[CTRL_MEMORY_CYCLE_WAIT_STATES_LSB +: MEMORY_CYCLE_WAIT_STATES_W];
	assign rdy_n = q.ctrl[CTRL_ASYNC_BIT] ? rdy_stable_n : rdy_direct_n;
	assign mc_load = tick && ((q.st == ST_ADDR && !q.ctrl[CTRL_RWD_BIT]) || q.st == ST_RWDLY);
	assign mc_dec = tick && (q.st == ST_MCWAIT);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.phase = !q.phase;
		d.done = 1'b0;

		if (tick) begin
			case (q.st)
				ST_IDLE: begin
					if (!hold_stable_n) begin
						d.hold_acknowledge_n = 1'b0;
						d.cs_oe = 1'b0;
						d.bus_oe = 1'b0;
						d.st = ST_HOLD;
					end else if (cycle_req_i) begin
						d.we = cycle_we_i;
						d.cs_n = ~cycle_cs_i;
						d.st = ST_ADDR;
					end
				end
				ST_ADDR, ST_RWDLY: begin
					if (q.st == ST_ADDR && q.ctrl[CTRL_RWD_BIT]) begin
						d.st = ST_RWDLY;
					end else begin
						d.rd_n = q.we;
						d.wr_n = !q.we;
						d.st = (memory_cycle_wait_states == '0) ? ST_CMD : ST_MCWAIT;
					end
				end
				ST_MCWAIT: begin
					if (mc_last) begin
						d.st = ST_CMD;
					end
				end
				ST_CMD: begin
					if (rdy_n) begin
						if (q.waits != '1) begin
							d.waits = q.waits + WAIT_CNT_W'(1);
						end
					end else begin
						d.rd_n = 1'b1;
						d.wr_n = 1'b1;
						d.cs_n = '1;
						d.done = 1'b1;
						d.last_waits = q.waits;
						d.waits = '0;
						if (q.ctrl[CTRL_MUX_BIT]) begin
							d.st = ST_MUXW;
						end else if (q.ctrl[CTRL_TRI_BIT]) begin
							d.st = ST_TRIW;
						end else begin
							d.st = ST_IDLE;
						end
					end
				end
				ST_MUXW: begin
					d.st = q.ctrl[CTRL_TRI_BIT] ? ST_TRIW : ST_IDLE;
				end
				ST_TRIW: begin
					d.st = ST_IDLE;
				end
				ST_HOLD: begin
					if (hold_stable_n) begin
						d.hold_acknowledge_n = 1'b1;
						d.bus_regain_request_n = 1'b1;
						d.cs_oe = 1'b1;
						d.bus_oe = 1'b1;
						d.st = ST_IDLE;
					end else begin
						d.bus_regain_request_n = !cycle_req_i;
					end
				end
				default: begin
					d.st = ST_IDLE;
				end
			endcase
		end

		// Register write
		if (s_axi_awvalid && !q.aw_have) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_have) begin
			d.w_have = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.aw_addr)
				ADDR_CTRL: begin
					if (q.w_strb[0]) begin
						d.ctrl = q.w_data[CTRL_W-1:0];
					end
				end
				ADDR_STATUS, ADDR_WAITS: begin
					d.bresp = RESP_OKAY;
				end
				default: begin
					d.bresp = RESP_DECERR;
				end
			endcase
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		// Register read
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			d.rdata = '0;
			case (s_axi_araddr)
				ADDR_CTRL: begin
					d.rdata[CTRL_W-1:0] = q.ctrl;
				end
				ADDR_STATUS: begin
					d.rdata[STAT_STATE_LSB +: 3] = q.st;
					d.rdata[STAT_HOLD_ACKNOWLEDGE_BIT] = !q.hold_acknowledge_n;
					d.rdata[STAT_BUS_REGAIN_REQUEST_BIT] = !q.bus_regain_request_n;
					d.rdata[STAT_BUSY_BIT] = (q.st != ST_IDLE) && (q.st != ST_HOLD);
					d.rdata[STAT_HOLDREQ_BIT] = !hold_stable_n;
				end
				ADDR_WAITS: begin
					d.rdata[WAIT_CNT_W-1:0] = q.last_waits;
				end
				default: begin
					d.rresp = RESP_DECERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '{
				phase: 1'b0, st: ST_IDLE, we: 1'b0, cs_n: '1, cs_oe: 1'b1,
				rd_n: 1'b1, wr_n: 1'b1, bus_oe: 1'b1, hold_acknowledge_n: 1'b1, bus_regain_request_n: 1'b1,
				done: 1'b0, waits: '0, last_waits: '0, ctrl: CTRL_RESET,
				aw_have: 1'b0, aw_addr: '0, w_have: 1'b0, w_data: '0, w_strb: '0,
				bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY
			};
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = !q.aw_have;
	assign s_axi_wready = !q.w_have;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	assign cycle_done_o = q.done;
	assign bus_clock_output_o = q.phase;
	assign hold_acknowledge_n_o = q.hold_acknowledge_n;
	assign bus_regain_request_n_o = q.bus_regain_request_n;
	assign chip_select_outputs_n_o = q.cs_n;
	assign chip_select_outputs_oe_o = q.cs_oe;
	assign rd_n_o = q.rd_n;
	assign wr_n_o = q.wr_n;
	assign bus_oe_o = q.bus_oe;

endmodule

/* File: ext_bus_pkg.sv */
// Shared constants, register map and state encoding of the external bus controller.
// Assumes a single 100 MHz clock and an AXI4-Lite register port with 32-bit data.
package ext_bus_pkg;

	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS      = 10;
	localparam int unsigned TCL_NS             = 10;
	localparam int unsigned ASYNC_READY_LOW_NS = 2 * TCL_NS + 10;
	localparam int unsigned ASYNC_READY_LOW_CYC =
		(ASYNC_READY_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_WAITS  = 8'h08;

	localparam int unsigned CTRL_W          = 8;
	localparam int unsigned CTRL_MUX_BIT    = 0;
	localparam int unsigned CTRL_TRI_BIT    = 1;
	localparam int unsigned CTRL_ASYNC_BIT  = 2;
	localparam int unsigned CTRL_RWD_BIT    = 3;
	localparam int unsigned CTRL_MEMORY_CYCLE_WAIT_STATES_LSB   = 4;
	localparam int unsigned MEMORY_CYCLE_WAIT_STATES_W          = 4;
	localparam logic [7:0]  CTRL_RESET      = 8'h04;

	localparam int unsigned STAT_STATE_LSB  = 0;
	localparam int unsigned STAT_HOLD_ACKNOWLEDGE_BIT   = 3;
	localparam int unsigned STAT_BUS_REGAIN_REQUEST_BIT   = 4;
	localparam int unsigned STAT_BUSY_BIT   = 5;
	localparam int unsigned STAT_HOLDREQ_BIT = 6;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// Bus side
	// ----------------------------------------------------------------
	localparam int unsigned CS_NUM    = 5;
	localparam int unsigned WAIT_CNT_W = 8;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_ADDR   = 3'h1,
		ST_RWDLY  = 3'h3,
		ST_MCWAIT = 3'h2,
		ST_CMD    = 3'h6,
		ST_MUXW   = 3'h7,
		ST_TRIW   = 3'h5,
		ST_HOLD   = 3'h4
	} bus_state_t;

endpackage

/* File: pin_sync.sv */
// Three-stage synchroniser for one pin input.
// Assumes the input is asynchronous to clk_i; stable output moves once stages two and three agree.
module pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic pin_i,
	output logic      direct_o,
	output logic      stable_o
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic stable;
	} sync_t;

	sync_t q, d;

	always_comb begin
		d = q;
		d.s1 = pin_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.stable = q.s3;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, stable: RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign direct_o = q.s2;
	assign stable_o = q.stable;

endmodule

/* File: wait_counter.sv */
// Loadable down counter for programmed wait states.
// Assumes load and decrement are never requested in the same cycle.
module wait_counter
	import ext_bus_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              nrst_i,
	input  wire logic              load_i,
	input  wire logic [MEMORY_CYCLE_WAIT_STATES_W-1:0] load_val_i,
	input  wire logic              dec_i,
	output logic                   last_o
);

	typedef struct packed {
		logic [MEMORY_CYCLE_WAIT_STATES_W-1:0] cnt;
	} cnt_t;

	cnt_t q, d;

	always_comb begin
		d = q;
		if (load_i) begin
			d.cnt = load_val_i;
		end else if (dec_i && (q.cnt != '0)) begin
			d.cnt = q.cnt - MEMORY_CYCLE_WAIT_STATES_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign last_o = (q.cnt == MEMORY_CYCLE_WAIT_STATES_W'(1));

endmodule

/* File: ext_bus_checker.sv */
// Pin-level assertions for ext_bus_ctrl.
// Assumes it is bound into ext_bus_ctrl; one clock, reset nrst_i.
module ext_bus_checker (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cycle_done_o,
	input wire logic bus_clock_output_o,
	input wire logic ready_n_i,
	input wire logic hold_n_i,
	input wire logic hold_acknowledge_n_o,
	input wire logic bus_regain_request_n_o,
	input wire logic chip_select_outputs_oe_o,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic bus_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic cmd = !rd_n_o || !wr_n_o;
	a_ready_wait: assert property ((cmd && ready_n_i) [*8] |=> cmd)
		else $error("command ended with ready high");
	a_done_cmd: assert property (cycle_done_o |-> !cmd && $past(cmd))
		else $error("done without command end");
	a_clk_pulse: assert property (bus_clock_output_o |=> !bus_clock_output_o)
		else $error("bus clock high too long");
	a_hold_acknowledge_tick: assert property ($changed(hold_acknowledge_n_o) |-> !bus_clock_output_o)
		else $error("acknowledge moved off a tick");
	a_hold_seen: assert property ($fell(hold_acknowledge_n_o) |-> $past(!hold_n_i, 3))
		else $error("acknowledge without hold");
	a_no_cmd_hold: assert property (!hold_acknowledge_n_o |-> !cmd)
		else $error("command during hold");
	a_bus_release: assert property (!hold_acknowledge_n_o |-> !chip_select_outputs_oe_o && !bus_oe_o)
		else $error("bus driven during hold");
	a_regain_hold: assert property (!bus_regain_request_n_o |-> !hold_acknowledge_n_o)
		else $error("regain request outside hold");
	a_hold_end: assert property (hold_n_i [*8] |=> hold_acknowledge_n_o)
		else $error("hold kept after request gone");
	a_bus_redrive: assert property ($rose(hold_acknowledge_n_o) |-> chip_select_outputs_oe_o && bus_oe_o)
		else $error("bus not redriven after hold");
endmodule

/* File: ext_bus_partner.sv */
// Memory with a tick-counted ready delay, and an external master asking for hold.
// Assumes the bench sets the delay and the hold request.
module ext_bus_partner
	import ext_bus_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              bclk_i,
	input  wire logic [CS_NUM-1:0] cs_n_i,
	input  wire logic              cs_oe_i,
	input  wire logic [7:0]        waits_i,
	input  wire logic              hold_req_i,
	output logic [CS_NUM-1:0]      cs_wire_o,
	output logic                   ready_n_o,
	output logic                   hold_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_q = 8'h00;
	logic       cs_q = 1'h1;
	logic       bclk_q = 1'h0;
	assign cs_wire_o = cs_oe_i ? cs_n_i : {CS_NUM{1'h1}};
	assign ready_n_o = cnt_q != 8'h00;
	assign hold_n_o = !hold_req_i;
	always @(posedge clk_i) begin
		cs_q <= &cs_wire_o;
		bclk_q <= bclk_i;
		if (cs_q && !(&cs_wire_o))
			cnt_q <= waits_i;
		else if (bclk_i && !bclk_q && cnt_q != 8'h00)
			cnt_q <= cnt_q - 8'h01;
	end
endmodule

/* File: tb.sv */
// Self-checking bench for ext_bus_ctrl with a pin partner.
// Assumes the package constants and the checker file.
module tb import ext_bus_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [7:0] ctrl, lead, dur, gap;} row_t;
	logic              clk_i = 1'h0, nrst_i = 1'h0, hold_req = 1'h0, pcs = 1'h1, pcmd = 1'h1;
	logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic              cycle_req_i = 1'h0, cycle_we_i = 1'h0;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic [CS_NUM-1:0] cycle_cs_i = 5'h01, chip_select_outputs_n_o, cs_w;
	logic [7:0]        waits = 8'h00;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              cycle_done_o, bus_clock_output_o, ready_n_i, hold_n_i, rd_n_o, wr_n_o;
	logic              hold_acknowledge_n_o, bus_regain_request_n_o;
	logic              chip_select_outputs_oe_o, bus_oe_o;
	int                fails = 0, checks_done = 0, cyc = 0, t_cs, t_cf, t_cr, t_d, t_dp, d6;
	row_t              rows [6] = '{'{8'h04, 8'h02, 8'h02, 8'h02}, '{8'h05, 8'h02, 8'h02, 8'h04},
		'{8'h07, 8'h02, 8'h02, 8'h06}, '{8'h0c, 8'h04, 8'h02, 8'h02},
		'{8'h34, 8'h02, 8'h08, 8'h02}, '{8'h10, 8'h02, 8'h04, 8'h02}};

	ext_bus_ctrl uut (.clk_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cycle_req_i, .cycle_we_i, .cycle_cs_i,
		.cycle_done_o, .bus_clock_output_o, .ready_n_i, .hold_n_i, .hold_acknowledge_n_o,
		.bus_regain_request_n_o, .chip_select_outputs_n_o, .chip_select_outputs_oe_o,
		.rd_n_o, .wr_n_o, .bus_oe_o);
	ext_bus_partner u_part (.clk_i, .bclk_i(bus_clock_output_o), .cs_n_i(chip_select_outputs_n_o),
		.cs_oe_i(chip_select_outputs_oe_o), .waits_i(waits), .hold_req_i(hold_req),
		.cs_wire_o(cs_w), .ready_n_o(ready_n_i), .hold_n_o(hold_n_i));

	// ------------------------------
	// Clock, monitor and helpers
	// ------------------------------
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc++;
		pcs <= &cs_w;
		pcmd <= rd_n_o && wr_n_o;
		if (pcs && !(&cs_w)) t_cs = cyc;
		if (pcmd && !(rd_n_o && wr_n_o)) t_cf = cyc;
		if (!pcmd && rd_n_o && wr_n_o) t_cr = cyc;
		if (cycle_done_o === 1'h1) begin
			t_dp = t_d;
			t_d = cyc;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task tally_and_finish();
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task tmo();
		fails++;
		tally_and_finish();
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return hold_acknowledge_n_o === 1'h0;
			1: return hold_acknowledge_n_o === 1'h1;
			2: return bus_regain_request_n_o === 1'h0;
			3: return cycle_done_o === 1'h1;
			default: return (rd_n_o && wr_n_o) === 1'h0;
		endcase
	endfunction
	task wt(input int k);
		int n;
		n = 0;
		while (!cond(k)) begin
			@(posedge clk_i);
			n++;
			if (n > 3000) tmo();
		end
	endtask
	task axi(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 99) tmo();
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'h1);
		s_axi_bready <= 1'h0;
		s_axi_rready <= 1'h0;
		chk(w ? s_axi_bresp : s_axi_rresp, er);
		if (!w) chk(s_axi_rdata, d);
	endtask
	task cyc2();
		cycle_req_i <= 1'h1;
		wt(3);
		@(posedge clk_i);
		wt(3);
		cycle_req_i <= 1'h0;
		@(posedge clk_i);
	endtask

	// ------------------------------
	// Sequence
	// ------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		axi(1'h0, ADDR_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY);
		axi(1'h1, 8'h0c, 32'h1, RESP_DECERR);
		axi(1'h0, 8'h0c, 32'h0, RESP_DECERR);
		foreach (rows[i]) begin
			axi(1'h1, ADDR_CTRL, {24'h0, rows[i].ctrl}, RESP_OKAY);
			axi(1'h0, ADDR_CTRL, {24'h0, rows[i].ctrl}, RESP_OKAY);
			cycle_we_i <= i[0];
			cycle_cs_i <= 5'h01 << (i % 5);
			cyc2();
			chk(t_cf - t_cs, rows[i].lead);
			chk(t_cr - t_cf, rows[i].dur);
			chk(t_cs - t_dp, rows[i].gap);
		end
		axi(1'h1, ADDR_CTRL, 32'h24, RESP_OKAY);
		waits <= 8'h06;
		cyc2();
		d6 = t_cr - t_cf;
		waits <= 8'h07;
		cyc2();
		chk(t_cr - t_cf - d6, 32'h2);
		axi(1'h1, ADDR_CTRL, 32'h20, RESP_OKAY);
		waits <= 8'h06;
		cyc2();
		chk(d6 - (t_cr - t_cf), 32'h2);
		waits <= 8'h10;
		cycle_req_i <= 1'h1;
		wt(4);
		hold_req <= 1'h1;
		d6 = cyc;
		wt(0);
		chk(t_d > d6, 1'h1);
		chk(rd_n_o && wr_n_o, 1'h1);
		chk({chip_select_outputs_oe_o, bus_oe_o, &cs_w}, 3'h1);
		wt(2);
		repeat (10) @(posedge clk_i);
		chk(hold_acknowledge_n_o, 1'h0);
		waits <= 8'h00;
		hold_req <= 1'h0;
		wt(1);
		chk({chip_select_outputs_oe_o, bus_oe_o, &cs_w}, 3'h7);
		wt(3);
		cycle_req_i <= 1'h0;
		hold_req <= 1'h1;
		wt(0);
		repeat (6) @(posedge clk_i);
		chk(bus_regain_request_n_o, 1'h1);
		hold_req <= 1'h0;
		wt(1);
		chk(bus_regain_request_n_o, 1'h1);
		nrst_i <= 1'h0;
		hold_req <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk({hold_acknowledge_n_o, chip_select_outputs_oe_o}, 2'h3);
		nrst_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		axi(1'h0, ADDR_CTRL, {24'h0, CTRL_RESET}, RESP_OKAY);
		tally_and_finish();
	end
endmodule

bind ext_bus_ctrl ext_bus_checker u_chk (.clk_i, .nrst_i, .cycle_done_o, .bus_clock_output_o,
	.ready_n_i, .hold_n_i, .hold_acknowledge_n_o, .bus_regain_request_n_o,
	.chip_select_outputs_oe_o, .rd_n_o, .wr_n_o, .bus_oe_o);
